// *** link_ser_pkg.sv ***
package link_ser_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned PCLK_LOSS_NS   = 2000;
  localparam int unsigned PCLK_LOSS_CYC  = (PCLK_LOSS_NS * CLK_MHZ) / 1000;
  localparam int unsigned IOSC_FRAME_NS  = 400;
  localparam int unsigned IOSC_FRAME_CYC = (IOSC_FRAME_NS * CLK_MHZ) / 1000;
  // ----------------------------------------------------------------
  // Register indices, byte address is index times four
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL  = 8'h03;
  localparam logic [7:0] IDX_MODE  = 8'h04;
  localparam logic [7:0] IDX_GPO   = 8'h05;
  localparam logic [7:0] IDX_STAT  = 8'h06;
  localparam logic [7:0] IDX_FWD   = 8'h07;
  localparam logic [7:0] IDX_CRC_A = 8'h0A;
  localparam logic [7:0] IDX_CRC_B = 8'h0B;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned EDGE_BIT   = 0;
  localparam int unsigned NOAUTO_BIT = 1;
  localparam int unsigned MODE12_BIT = 0;
  localparam int unsigned EXTOSC_BIT = 1;
  localparam logic [7:0]  CTRL_RST   = 8'h01;
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [7:0]  GPO_RST    = 8'h00;
  localparam logic [7:0]  FWD_RST    = 8'h00;
  localparam int unsigned FRAME_W    = 28;
  localparam int unsigned BC_W       = 12;
  localparam logic [3:0]  CRC_POLY   = 4'h3;
  localparam logic [15:0] LFSR_SEED  = 16'hACE1;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Clock source states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_OFF  = 3'b001,
    SRC_IOSC = 3'b010,
    SRC_PCLK = 3'b100
  } clk_src_e;
endpackage

// *** aux_if.sv ***
`timescale 1ns/1ns
interface aux_if;
  logic                                 load;
  logic [link_ser_pkg::FRAME_W-1:0]     raw;
  logic [link_ser_pkg::FRAME_W-1:0]     coded;
  logic [link_ser_pkg::BC_W-1:0]        bc_msg;
  logic                                 bc_ok;
  modport top (output load, output raw, output bc_msg, input coded, input bc_ok);
  modport scr (input load, input raw, output coded);
  modport crc (input bc_msg, output bc_ok);
endinterface

// *** frame_scrambler.sv ***
`timescale 1ns/1ns
module frame_scrambler (
  input  wire logic aclk,
  input  wire logic aresetn,
  aux_if.scr        sif
);
  logic [15:0] lfsr_q;
  logic        odd_q;
  wire  [27:0] mask = {lfsr_q, lfsr_q[11:0]};
  wire  [27:0] mixed = sif.raw ^ mask;
  // ----------------------------------------------------------------
  // Randomize, scramble, then balance by alternate inversion
  // ----------------------------------------------------------------
  assign sif.coded = odd_q ? ~mixed : mixed;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_q <= link_ser_pkg::LFSR_SEED;
      odd_q  <= 1'b0;
    end else if (sif.load) begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      odd_q  <= ~odd_q;
    end
  end
endmodule // frame_scrambler

// *** back_crc_check.sv ***
`timescale 1ns/1ns
module back_crc_check (
  aux_if.crc cif
);
  function automatic logic [3:0] crc4(input logic [7:0] d);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? link_ser_pkg::CRC_POLY : 4'h0);
    end
    return c;
  endfunction
  // ----------------------------------------------------------------
  // Four check bits over the eight message bits
  // ----------------------------------------------------------------
  assign cif.bc_ok = (crc4(cif.bc_msg[11:4]) == cif.bc_msg[3:0]);
endmodule // back_crc_check

// *** link_ser_core.sv ***
`timescale 1ns/1ns
module link_ser_core #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              pclk,
  input  wire logic [11:0]       pixel_data,
  input  wire logic              line_sync,
  input  wire logic              frame_sync,
  input  wire logic              power_down_bar,
  input  wire logic              bc_valid,
  input  wire logic [11:0]       bc_msg,
  input  wire logic [3:0]        gpo_in,
  output logic [3:0]             gpo_out,
  output logic [3:0]             gpo_oe,
  output logic [27:0]            ser_frame,
  output logic                   ser_frame_valid
);
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0]              ctrl_q, mode_q, gpo_cfg_q, fwd_q;
  logic [15:0]             crc_cnt_q;
  logic [3:0]              remote_q;
  logic [3:0]              gpo_out_q, gpo_oe_q;
  logic                    half_clk_q, osc_prev_q;
  logic                    pclk_q;
  logic [15:0]             loss_q;
  link_ser_pkg::clk_src_e  src_q, src_d;
  logic [41:0]             sr_q;
  logic [1:0]              pix_cnt_q;
  logic [2:0]              ctl_ptr_q;
  logic [15:0]             iosc_cnt_q;
  logic [27:0]             ser_q;
  logic                    ser_v_q;
  logic                    awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [ADDR_W-1:0]       awaddr_q;
  logic [7:0]              wdata_q;
  logic                    wlane_q;
  logic [1:0]              bresp_q, rresp_q;
  logic [31:0]             rdata_q;

  aux_if aif ();

  frame_scrambler u_scr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sif     (aif.scr)
  );

  back_crc_check u_crc (
    .cif (aif.crc)
  );

  // ----------------------------------------------------------------
  // Pixel clock sampling and edge select
  // ----------------------------------------------------------------
  wire edge_sel   = ctrl_q[link_ser_pkg::EDGE_BIT];
  wire no_auto    = ctrl_q[link_ser_pkg::NOAUTO_BIT];
  wire mode12     = mode_q[link_ser_pkg::MODE12_BIT];
  wire ext_osc    = mode_q[link_ser_pkg::EXTOSC_BIT];
  wire pclk_rise  = pclk & ~pclk_q;
  wire pclk_fall  = ~pclk & pclk_q;
  wire pclk_edge  = pclk_rise | pclk_fall;
  wire pix_edge   = edge_sel ? pclk_rise : pclk_fall;
  wire pclk_lost  = (loss_q >= 16'(link_ser_pkg::PCLK_LOSS_CYC));

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  always_comb begin
    src_d = src_q;
    case (src_q)
      link_ser_pkg::SRC_OFF: begin
        if (power_down_bar) src_d = link_ser_pkg::SRC_IOSC;
      end
      link_ser_pkg::SRC_IOSC: begin
        if (!power_down_bar) src_d = link_ser_pkg::SRC_OFF;
        else if (pclk_edge && !no_auto) src_d = link_ser_pkg::SRC_PCLK;
      end
      link_ser_pkg::SRC_PCLK: begin
        if (!power_down_bar) src_d = link_ser_pkg::SRC_OFF;
        else if (pclk_lost || no_auto) src_d = link_ser_pkg::SRC_IOSC;
      end
      default: src_d = link_ser_pkg::SRC_OFF;
    endcase
  end

  wire in_pclk = (src_q == link_ser_pkg::SRC_PCLK);
  wire in_iosc = (src_q == link_ser_pkg::SRC_IOSC);
  wire link_on = (src_q != link_ser_pkg::SRC_OFF);

  // ----------------------------------------------------------------
  // Frame packing
  // ----------------------------------------------------------------
  wire        cap      = in_pclk & pix_edge;
  wire [13:0] pix14    = {frame_sync, line_sync, pixel_data};
  wire [11:0] pix12    = {frame_sync, line_sync, pixel_data[9:0]};
  wire [41:0] sr_d     = mode12 ? {sr_q[27:0], pix14} : {sr_q[29:0], pix12};
  wire        last12   = (pix_cnt_q == 2'd2);
  wire        emit10   = cap & ~mode12 & (pix_cnt_q == 2'd1);
  wire        emit12   = cap & mode12 & (pix_cnt_q != 2'd0);
  wire        iosc_end = in_iosc & (iosc_cnt_q >= 16'(link_ser_pkg::IOSC_FRAME_CYC - 1));
  wire        emit     = emit10 | emit12 | iosc_end;
  wire [15:0] ctl_dbl  = {fwd_q, fwd_q} >> ctl_ptr_q;
  wire [20:0] pay21    = last12 ? sr_d[20:0] : sr_d[27:7];
  wire [26:0] pay10    = {ctl_dbl[2:0], (in_pclk ? sr_d[23:0] : 24'h000000)};
  wire [26:0] pay12    = {ctl_dbl[5:0], (in_pclk ? pay21 : 21'h000000)};
  wire [26:0] payload  = mode12 ? pay12 : pay10;
  wire        parity   = ^payload;

  assign aif.raw    = {payload, parity};
  assign aif.load   = emit & link_on;
  assign aif.bc_msg = bc_msg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q      <= link_ser_pkg::SRC_OFF;
      pclk_q     <= 1'b0;
      loss_q     <= 16'h0000;
      sr_q       <= '0;
      pix_cnt_q  <= 2'd0;
      ctl_ptr_q  <= 3'd0;
      iosc_cnt_q <= 16'h0000;
    end else begin
      src_q  <= src_d;
      pclk_q <= pclk;
      if (pclk_edge) loss_q <= 16'h0000;
      else if (!pclk_lost) loss_q <= loss_q + 16'h0001;
      if (!in_pclk) begin
        pix_cnt_q <= 2'd0;
      end else if (cap) begin
        sr_q      <= sr_d;
        pix_cnt_q <= ((mode12 && last12) || (!mode12 && pix_cnt_q == 2'd1))
                     ? 2'd0 : pix_cnt_q + 2'd1;
      end
      if (iosc_end || !in_iosc) iosc_cnt_q <= 16'h0000;
      else iosc_cnt_q <= iosc_cnt_q + 16'h0001;
      if (aif.load) ctl_ptr_q <= ctl_ptr_q + (mode12 ? 3'd6 : 3'd3);
    end
  end

  // ----------------------------------------------------------------
  // Serial frame output
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_q   <= '1;
      ser_v_q <= 1'b0;
    end else if (!link_on) begin
      ser_q   <= '1;
      ser_v_q <= 1'b0;
    end else begin
      ser_v_q <= aif.load;
      if (aif.load) ser_q <= aif.coded;
    end
  end

  // ----------------------------------------------------------------
  // Back channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_cnt_q <= 16'h0000;
      remote_q  <= 4'h0;
    end else if (bc_valid) begin
      if (!aif.bc_ok) begin
        if (crc_cnt_q != 16'hFFFF) crc_cnt_q <= crc_cnt_q + 16'h0001;
      end else begin
        remote_q <= bc_msg[11:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // General outputs
  // ----------------------------------------------------------------
  logic [3:0] gpo_d, oe_d;
  for (genvar i = 0; i < 4; i++) begin : g_gpo
    wire mirror = gpo_cfg_q[i] ? remote_q[i] : gpo_cfg_q[4+i];
    if (i == 2) begin : g_half
      assign gpo_d[i] = ext_osc ? half_clk_q : mirror;
      assign oe_d[i]  = 1'b1;
    end else if (i == 3) begin : g_oscin
      assign gpo_d[i] = ext_osc ? 1'b0 : mirror;
      assign oe_d[i]  = ~ext_osc;
    end else begin : g_plain
      assign gpo_d[i] = mirror;
      assign oe_d[i]  = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpo_out_q  <= 4'h0;
      gpo_oe_q   <= 4'hF;
      half_clk_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      gpo_out_q  <= gpo_d;
      gpo_oe_q   <= oe_d;
      osc_prev_q <= gpo_in[3];
      if (!ext_osc) half_clk_q <= 1'b0;
      else if (gpo_in[3] && !osc_prev_q) half_clk_q <= ~half_clk_q;
    end
  end

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  wire [7:0] w_idx  = awaddr_q[9:2];
  wire       w_ok   = (awaddr_q[ADDR_W-1:10] == '0) && (awaddr_q[1:0] == 2'b00);
  wire       w_ctrl = w_ok && (w_idx == link_ser_pkg::IDX_CTRL);
  wire       w_mode = w_ok && (w_idx == link_ser_pkg::IDX_MODE);
  wire       w_gpo  = w_ok && (w_idx == link_ser_pkg::IDX_GPO);
  wire       w_fwd  = w_ok && (w_idx == link_ser_pkg::IDX_FWD);
  wire       w_ro   = w_ok && (w_idx == link_ser_pkg::IDX_STAT || w_idx == link_ser_pkg::IDX_CRC_A
                               || w_idx == link_ser_pkg::IDX_CRC_B);
  wire       w_hit  = w_ctrl | w_mode | w_gpo | w_fwd | w_ro;
  wire       do_wr  = ~awready_q & ~wready_q & ~bvalid_q;
  wire       wr_en  = do_wr & wlane_q;

  wire [7:0] r_idx  = araddr[9:2];
  wire       r_ok   = (araddr[ADDR_W-1:10] == '0) && (araddr[1:0] == 2'b00);
  wire [7:0] status = {5'h00, in_pclk, ~pclk_lost, link_on};
  logic [7:0] r_val;
  logic       r_hit;
  always_comb begin
    r_val = 8'h00;
    r_hit = r_ok;
    case (r_idx)
      link_ser_pkg::IDX_CTRL:  r_val = ctrl_q;
      link_ser_pkg::IDX_MODE:  r_val = mode_q;
      link_ser_pkg::IDX_GPO:   r_val = gpo_cfg_q;
      link_ser_pkg::IDX_STAT:  r_val = status;
      link_ser_pkg::IDX_FWD:   r_val = fwd_q;
      link_ser_pkg::IDX_CRC_A: r_val = crc_cnt_q[7:0];
      link_ser_pkg::IDX_CRC_B: r_val = crc_cnt_q[15:8];
      default:                 r_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= link_ser_pkg::RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end else begin
      if (awvalid && awready_q) begin
        awaddr_q  <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        wdata_q  <= wdata[7:0];
        wlane_q  <= wstrb[0];
        wready_q <= 1'b0;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= w_hit ? link_ser_pkg::RESP_OKAY : link_ser_pkg::RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= link_ser_pkg::CTRL_RST;
      mode_q    <= link_ser_pkg::MODE_RST;
      gpo_cfg_q <= link_ser_pkg::GPO_RST;
      fwd_q     <= link_ser_pkg::FWD_RST;
    end else if (wr_en) begin
      if (w_ctrl) ctrl_q <= wdata_q;
      if (w_mode) mode_q <= wdata_q;
      if (w_gpo) gpo_cfg_q <= wdata_q;
      if (w_fwd) fwd_q <= wdata_q;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= link_ser_pkg::RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h000000, r_val};
      rresp_q   <= r_hit ? link_ser_pkg::RESP_OKAY : link_ser_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready         = awready_q;
  assign wready          = wready_q;
  assign bvalid          = bvalid_q;
  assign bresp           = bresp_q;
  assign arready         = arready_q;
  assign rvalid          = rvalid_q;
  assign rdata           = rdata_q;
  assign rresp           = rresp_q;
  assign gpo_out         = gpo_out_q;
  assign gpo_oe          = gpo_oe_q;
  assign ser_frame       = ser_q;
  assign ser_frame_valid = ser_v_q;
endmodule // link_ser_core

// *** link_ser_checker.sv ***
`timescale 1ns/1ns
module link_ser_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic        power_down_bar,
  input wire logic [3:0]  gpo_in,
  input wire logic [3:0]  gpo_out,
  input wire logic [3:0]  gpo_oe,
  input wire logic [27:0] ser_frame,
  input wire logic        ser_frame_valid
);
  // ------------------------
  // Properties
  // ------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_pd_low; (!power_down_bar) [*3]; endsequence
  sequence s_wr_both; awvalid && awready && wvalid && wready; endsequence
  sequence s_osc_rise; $rose(gpo_in[3]) && !gpo_oe[3]; endsequence
  property p_pd_static; s_pd_low |-> ser_frame == 28'hFFFFFFF && !ser_frame_valid; endproperty
  a_pd_static: assert property (p_pd_static)
    else $error("frame not static high");
  property p_valid_pulse; ser_frame_valid |=> !ser_frame_valid; endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("frame strobe too long");
  property p_frame_hold; !ser_frame_valid && power_down_bar |-> $stable(ser_frame); endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("frame changed without strobe");
  property p_wr_resp; s_wr_both |-> ##2 bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response missing");
  property p_rd_resp; arvalid && arready |=> rvalid && rdata[31:8] == 24'h000000; endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read response wrong");
  property p_oe_fixed; gpo_oe[2:0] == 3'h7; endproperty
  a_oe_fixed: assert property (p_oe_fixed)
    else $error("general pin not driven");
  property p_ext_toggle; s_osc_rise |-> ##[0:4] $changed(gpo_out[2]); endproperty
  a_ext_toggle: assert property (p_ext_toggle)
    else $error("half rate clock did not toggle");
  property p_relock; $rose(power_down_bar) |-> ##[1:30] ser_frame_valid; endproperty
  a_relock: assert property (p_relock)
    else $error("no frame after enable");
endmodule // link_ser_checker

bind link_ser_core link_ser_checker chk_i (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
  .rvalid, .rdata, .power_down_bar, .gpo_in, .gpo_out, .gpo_oe, .ser_frame, .ser_frame_valid
);

// *** far_end_model.sv ***
`timescale 1ns/1ns
module far_end_model (
  input  wire logic   aclk,
  input  wire logic   pclk_en,
  input  wire logic   osc_en,
  output logic        pclk,
  output logic [11:0] pixel_data,
  output logic        line_sync,
  output logic        frame_sync,
  output logic        osc_clk,
  output logic        bc_valid,
  output logic [11:0] bc_msg
);
  // ------------------------
  // Imager and oscillator
  // ------------------------
  logic [1:0] pdiv_q = 2'h0;
  logic [2:0] odiv_q = 3'h0;
  initial begin
    pclk = 1'b0;
    pixel_data = 12'h000;
    {line_sync, frame_sync, osc_clk, bc_valid} = 4'h0;
    bc_msg = 12'h000;
  end
  always @(posedge aclk) begin
    odiv_q <= (odiv_q == 3'h5) ? 3'h0 : odiv_q + 3'h1;
    if (osc_en && odiv_q == 3'h5) osc_clk <= ~osc_clk;
    if (pclk_en) begin
      pdiv_q <= (pdiv_q == 2'h2) ? 2'h0 : pdiv_q + 2'h1;
      if (pdiv_q == 2'h2) pclk <= ~pclk;
      if (pdiv_q == 2'h2 && pclk) begin
        pixel_data <= pixel_data + 12'h001;
        line_sync  <= pixel_data[4];
        frame_sync <= pixel_data[5];
      end
    end else begin
      pixel_data <= ~pixel_data;
    end
  end
  // ------------------------
  // Back channel
  // ------------------------
  function automatic logic [3:0] crc4(input logic [7:0] d);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 7; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'h3 : 4'h0);
    return c;
  endfunction
  task automatic send_bc(input logic [3:0] gp, input logic bad);
    logic [11:0] m;
    m = {gp, 4'h0, crc4({gp, 4'h0}) ^ {3'h0, bad}};
    @(posedge aclk);
    bc_msg   <= m;
    bc_valid <= 1'b1;
    @(posedge aclk);
    bc_valid <= 1'b0;
    bc_msg   <= ~m;
    repeat (380) @(posedge aclk);
  endtask
endmodule // far_end_model

// *** camera_link_serializer_core_tb_top.sv ***
`timescale 1ns/1ns
module camera_link_serializer_core_tb_top;
  // ------------------------
  // Signals
  // ------------------------
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        power_down_bar, pclk_en, osc_en, p;
  logic        awready, wready, bvalid, arready, rvalid, ser_frame_valid;
  logic        pclk, line_sync, frame_sync, osc_clk, bc_valid;
  logic [11:0] awaddr, araddr, pixel_data, bc_msg;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, gpo_in, gpo_out, gpo_oe;
  logic [1:0]  bresp, rresp;
  logic [27:0] ser_frame;
  int          errors, cmp_count, n, m, k, par_errs;
  localparam logic [7:0] R_IX [7] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h0A, 8'h0B, 8'h20};
  localparam logic [7:0] R_EV [7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [1:0] R_ER [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  assign gpo_in = (gpo_oe & gpo_out) | (~gpo_oe & {osc_clk, 3'h0});
  logic [15:0] fe_lfsr;
  always @(posedge aclk) begin
    if (!aresetn) begin
      fe_lfsr <= link_ser_pkg::LFSR_SEED;
    end else if (ser_frame_valid) begin
      fe_lfsr <= {fe_lfsr[14:0], fe_lfsr[15] ^ fe_lfsr[13] ^ fe_lfsr[12] ^ fe_lfsr[10]};
      if (^{ser_frame, fe_lfsr, fe_lfsr[11:0]}) par_errs <= par_errs + 1;
    end
  end
  link_ser_core uut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .pclk, .pixel_data, .line_sync, .frame_sync, .power_down_bar, .bc_valid,
    .bc_msg, .gpo_in, .gpo_out, .gpo_oe, .ser_frame, .ser_frame_valid
  );
  far_end_model far (
    .aclk, .pclk_en, .osc_en, .pclk, .pixel_data, .line_sync, .frame_sync, .osc_clk,
    .bc_valid, .bc_msg
  );
  always #20 aclk = ~aclk;
  // ------------------------
  // Tasks
  // ------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] v, input logic [1:0] er);
    logic a, w, b;
    logic [1:0] r;
    b = 1'b0;
    @(posedge aclk);
    awaddr  <= {2'h0, ix, 2'h0};
    wdata   <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask
  task automatic rd(input logic [7:0] ix, input logic [31:0] ev, input logic [1:0] er);
    logic t, d;
    logic [31:0] v;
    logic [1:0] r;
    d = 1'b0;
    @(posedge aclk);
    araddr  <= {2'h0, ix, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!d) begin
      @(negedge aclk);
      t = arvalid && arready;
      d = rvalid;
      v = rdata;
      r = rresp;
      @(posedge aclk);
      if (t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(v, ev);
    chk(32'(r), 32'(er));
  endtask
  task automatic gap(output int c);
    for (int i = 0; i < 200 && !ser_frame_valid; i++) @(negedge aclk);
    @(negedge aclk);
    for (c = 1; c < 200 && !ser_frame_valid; c++) @(negedge aclk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------
  // Sequence
  // ------------------------
  initial begin
    #(20000 * 40);
    errors++;
    give_verdict();
  end
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {power_down_bar, pclk_en, osc_en} = 3'b100;
    {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hF};
    {errors, cmp_count} = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(R_IX[i], 32'(R_EV[i]), R_ER[i]);
    wr(link_ser_pkg::IDX_CRC_A, 8'hFF, link_ser_pkg::RESP_OKAY);
    rd(link_ser_pkg::IDX_CRC_A, 32'h0, link_ser_pkg::RESP_OKAY);
    wr(8'h3F, 8'h01, link_ser_pkg::RESP_SLVERR);
    $display("test registers done");
    wr(link_ser_pkg::IDX_GPO, 8'h0F, link_ser_pkg::RESP_OKAY);
    repeat (3) far.send_bc(4'h6, 1'b1);
    rd(link_ser_pkg::IDX_CRC_A, 32'h3, link_ser_pkg::RESP_OKAY);
    rd(link_ser_pkg::IDX_CRC_B, 32'h0, link_ser_pkg::RESP_OKAY);
    far.send_bc(4'hA, 1'b0);
    chk(32'(gpo_out), 32'hA);
    wr(link_ser_pkg::IDX_GPO, 8'h50, link_ser_pkg::RESP_OKAY);
    @(negedge aclk);
    chk(32'(gpo_out), 32'h5);
    chk(32'(gpo_oe), 32'hF);
    $display("test back channel done");
    gap(n);
    chk(n, link_ser_pkg::IOSC_FRAME_CYC);
    @(posedge aclk);
    pclk_en <= 1'b1;
    repeat (40) @(posedge aclk);
    rd(link_ser_pkg::IDX_STAT, 32'h7, link_ser_pkg::RESP_OKAY);
    gap(n);
    chk(n, 12);
    wr(link_ser_pkg::IDX_MODE, 8'h01, link_ser_pkg::RESP_OKAY);
    repeat (2) gap(n);
    gap(n);
    gap(m);
    chk(n + m, 18);
    @(posedge aclk);
    pclk_en <= 1'b0;
    wr(link_ser_pkg::IDX_MODE, 8'h00, link_ser_pkg::RESP_OKAY);
    repeat (link_ser_pkg::PCLK_LOSS_CYC + 20) @(posedge aclk);
    gap(n);
    chk(n, link_ser_pkg::IOSC_FRAME_CYC);
    wr(link_ser_pkg::IDX_CTRL, 8'h03, link_ser_pkg::RESP_OKAY);
    pclk_en <= 1'b1;
    repeat (40) @(posedge aclk);
    gap(n);
    chk(n, link_ser_pkg::IOSC_FRAME_CYC);
    wr(link_ser_pkg::IDX_CTRL, 8'h00, link_ser_pkg::RESP_OKAY);
    repeat (40) @(posedge aclk);
    gap(n);
    chk(n, 12);
    pclk_en <= 1'b0;
    wr(link_ser_pkg::IDX_CTRL, 8'h01, link_ser_pkg::RESP_OKAY);
    $display("test clock source done");
    wr(link_ser_pkg::IDX_MODE, 8'h02, link_ser_pkg::RESP_OKAY);
    osc_en <= 1'b1;
    repeat (20) @(negedge aclk);
    chk(32'(gpo_oe[3]), 32'h0);
    k = 0;
    p = gpo_out[2];
    repeat (96) begin
      @(negedge aclk);
      if (gpo_out[2] !== p) k++;
      p = gpo_out[2];
    end
    chk(k, 8);
    osc_en <= 1'b0;
    wr(link_ser_pkg::IDX_MODE, 8'h00, link_ser_pkg::RESP_OKAY);
    $display("test oscillator done");
    power_down_bar <= 1'b0;
    repeat (4) @(posedge aclk);
    k = 0;
    repeat (30) begin
      @(negedge aclk);
      if (ser_frame_valid !== 1'b0) k++;
    end
    chk(32'(ser_frame), 32'hFFFFFFF);
    chk(k, 0);
    @(posedge aclk);
    power_down_bar <= 1'b1;
    gap(n);
    chk(n, link_ser_pkg::IOSC_FRAME_CYC);
    $display("test power down done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(negedge aclk);
    chk(32'(ser_frame), 32'hFFFFFFF);
    chk(32'(gpo_out), 32'h0);
    repeat (14) @(posedge aclk);
    aresetn <= 1'b1;
    rd(link_ser_pkg::IDX_CRC_A, 32'h0, link_ser_pkg::RESP_OKAY);
    rd(link_ser_pkg::IDX_CTRL, 32'h1, link_ser_pkg::RESP_OKAY);
    $display("test second reset done");
    chk(par_errs, 0);
    give_verdict();
  end
endmodule // camera_link_serializer_core_tb_top
